/* core/irq_ctrl.sv */
`timescale 1ns/1ps
`include "irq_ctrl_consts.svh"
module irq_ctrl import irq_ctrl_pkg::*; #(
  parameter int N = `NUM_SOURCES
) (
  input wire logic clk, // 50 MHz system clock
  input wire logic sys_rst, // Async reset, high
  input wire logic [N-1:0] pendFlags, // Peripheral pending flags, same clock
  input wire logic regWr, // Register write strobe
  input wire logic [7:0] regAddr, // Register address
  input wire logic [7:0] regWdata, // Write data
  input wire logic instrDone, // Core finished an instruction
  input wire logic retiDone, // Core finished a return-from-interrupt
  input wire logic callDone, // Unused in timing; core took the call
  output logic [7:0] regRdata, // Registered read data
  output logic callReq, // Vectored call request to core
  output logic [15:0] callVector, // Vector address of winner
  output logic [1:0] inService // Active levels: bit1 high, bit0 low
);
  typedef struct packed {
    logic [7:0] enA, enB, enC, prA, prB, prC;
    seq_t seq;
    logic [4:0] winner;
    logic winHigh;
    logic [2:0] callCnt;
    logic [1:0] active;
    logic [7:0] rdata;
    logic [15:0] vec;
    logic call;
  } state_t;
  state_t q, d;
  logic [N-1:0] enables, levels, candHi, candLo;
  logic hiFound, loFound;
  logic [4:0] hiIdx, loIdx;
  // Source vectors in source order 0..21
  assign enables = {q.enC, q.enB, q.enA[5:0]};
  assign levels = {q.prC, q.prB, q.prA[5:0]};
  // Qualified requests every cycle; global bit gates all
  assign candHi = pendFlags & enables & levels & {N{q.enA[`GLOBAL_ON_BIT]}};
  assign candLo = pendFlags & enables & ~levels & {N{q.enA[`GLOBAL_ON_BIT]}};
  prio_pick #(.N(N)) pickHi (.req(candHi), .found(hiFound), .index(hiIdx));
  prio_pick #(.N(N)) pickLo (.req(candLo), .found(loFound), .index(loIdx));
  always_comb begin
    d = q;
    d.call = 1'b0;
    // Register writes; top priority A bits fixed
    if (regWr) begin
      case (regAddr)
        `ADDR_ENABLE_A: d.enA = regWdata;
        `ADDR_PRIORITY_A: d.prA = regWdata | `PRIORITY_A_FIXED;
        `ADDR_ENABLE_B: d.enB = regWdata;
        `ADDR_ENABLE_C: d.enC = regWdata;
        `ADDR_PRIORITY_B: d.prB = regWdata;
        `ADDR_PRIORITY_C: d.prC = regWdata;
        default: d.rdata = q.rdata;
      endcase
    end
    // Registered read mux
    case (regAddr)
      `ADDR_ENABLE_A: d.rdata = q.enA;
      `ADDR_PRIORITY_A: d.rdata = q.prA;
      `ADDR_ENABLE_B: d.rdata = q.enB;
      `ADDR_ENABLE_C: d.rdata = q.enC;
      `ADDR_PRIORITY_B: d.rdata = q.prB;
      `ADDR_PRIORITY_C: d.rdata = q.prC;
      default: d.rdata = 8'h00;
    endcase
    // Release the newest level on return
    if (retiDone) begin
      if (q.active[1]) d.active[1] = 1'b0;
      else d.active[0] = 1'b0;
    end
    case (q.seq)
      IDLE: begin
        // High beats low; high not preempted; low waits equal level
        if (!retiDone) begin
          if (hiFound && !q.active[1]) begin
            d.seq = DETECT;
            d.winner = hiIdx;
            d.winHigh = 1'b1;
          end else if (loFound && q.active == 2'b00) begin
            d.seq = DETECT;
            d.winner = loIdx;
            d.winHigh = 1'b0;
          end
        end
      end
      DETECT: begin
        // Wait for a boundary that is not the return itself
        if (instrDone && !retiDone) begin
          d.seq = CALL;
          d.callCnt = 3'(`CALL_CLOCKS);
          d.call = 1'b1;
          d.vec = `VECTOR_BASE + 16'(q.winner) * `VECTOR_STEP;
        end
      end
      CALL: begin
        // Four call clocks then mark level active
        d.callCnt = q.callCnt - 3'h1;
        if (q.callCnt == 3'h1) begin
          d.seq = IDLE;
          d.callCnt = 3'h0;
          if (q.winHigh) d.active[1] = 1'b1;
          else d.active[0] = 1'b1;
        end
      end
      default: d.seq = IDLE;
    endcase
  end
  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.prA <= `RESET_PRIORITY_A;
      q.enA <= `RESET_ENABLE;
    end else begin
      q <= d;
    end
  end
  assign regRdata = q.rdata;
  assign callReq = q.call;
  assign callVector = q.vec;
  assign inService = q.active;
  // Checks
  global_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    !q.enA[`GLOBAL_ON_BIT] && q.seq == IDLE |=> q.seq != DETECT)
    else $error("request accepted while globally disabled");
  prio_fixed_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.prA[7:6] == 2'b11)
    else $error("priority A top bits not one");
  call_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    callReq |-> q.seq == CALL ##4 q.seq == IDLE)
    else $error("call did not last four clocks");
  high_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.active[1] && q.seq == IDLE && !retiDone |=> q.seq == IDLE)
    else $error("high routine preempted");
  after_ret_a: assert property (@(posedge clk) disable iff (sys_rst)
    retiDone |=> !callReq)
    else $error("call taken right after return");
  vec_map_a: assert property (@(posedge clk) disable iff (sys_rst)
    callReq |-> callVector == 16'h0003 + 16'(q.winner) * 16'h0008)
    else $error("wrong vector");
  high_win_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.seq == IDLE && hiFound && q.active == 2'b00 && !retiDone |=> q.winHigh)
    else $error("low won over high");
  low_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.seq == IDLE && q.active[0] && !hiFound |=> q.seq == IDLE)
    else $error("low accepted during low service");
  // Register writes land one clock later
  en_a_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    regWr && regAddr == `ADDR_ENABLE_A |=> q.enA == $past(regWdata))
    else $error("enable A write lost");
  pr_a_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    regWr && regAddr == `ADDR_PRIORITY_A |=> q.prA[5:0] == $past(regWdata[5:0]))
    else $error("priority A write lost");
  en_b_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    regWr && regAddr == `ADDR_ENABLE_B |=> q.enB == $past(regWdata))
    else $error("enable B write lost");
  en_c_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    regWr && regAddr == `ADDR_ENABLE_C |=> q.enC == $past(regWdata))
    else $error("enable C write lost");
  pr_b_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    regWr && regAddr == `ADDR_PRIORITY_B |=> q.prB == $past(regWdata))
    else $error("priority B write lost");
  pr_c_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    regWr && regAddr == `ADDR_PRIORITY_C |=> q.prC == $past(regWdata))
    else $error("priority C write lost");
  // Read data follows the address by one clock
  rd_en_a_a: assert property (@(posedge clk) disable iff (sys_rst)
    regAddr == `ADDR_ENABLE_A |=> regRdata == $past(q.enA))
    else $error("enable A read wrong");
  rd_pr_a_a: assert property (@(posedge clk) disable iff (sys_rst)
    regAddr == `ADDR_PRIORITY_A |=> regRdata[7:6] == 2'b11)
    else $error("priority A read top bits wrong");
  rd_en_b_a: assert property (@(posedge clk) disable iff (sys_rst)
    regAddr == `ADDR_ENABLE_B |=> regRdata == $past(q.enB))
    else $error("enable B read wrong");
  rd_en_c_a: assert property (@(posedge clk) disable iff (sys_rst)
    regAddr == `ADDR_ENABLE_C |=> regRdata == $past(q.enC))
    else $error("enable C read wrong");
  rd_pr_b_a: assert property (@(posedge clk) disable iff (sys_rst)
    regAddr == `ADDR_PRIORITY_B |=> regRdata == $past(q.prB))
    else $error("priority B read wrong");
  rd_pr_c_a: assert property (@(posedge clk) disable iff (sys_rst)
    regAddr == `ADDR_PRIORITY_C |=> regRdata == $past(q.prC))
    else $error("priority C read wrong");
  rd_none_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(regAddr inside {`ADDR_ENABLE_A, `ADDR_PRIORITY_A, `ADDR_ENABLE_B,
      `ADDR_ENABLE_C, `ADDR_PRIORITY_B, `ADDR_PRIORITY_C}) |=> regRdata == 8'h00)
    else $error("unmapped address read nonzero");
  // Call starts only at an instruction boundary
  boundary_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.seq == DETECT && !instrDone |=> !callReq)
    else $error("call started inside an instruction");
  detect_go_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.seq == DETECT && instrDone && !retiDone |=> callReq)
    else $error("call not started at boundary");
  call_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    callReq |=> !callReq)
    else $error("call request longer than one clock");
  vec_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !callReq |-> $stable(callVector))
    else $error("vector changed without a call");
  seq_legal_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.seq != HOLD)
    else $error("sequencer in unused state");
  // Masking, pick order and level tracking
  mask_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.seq == IDLE && !(|(pendFlags & enables)) |=> q.seq == IDLE)
    else $error("masked source accepted");
  low_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.seq == IDLE && !retiDone && !hiFound && loFound && q.active == 2'b00
    |=> q.winner == $past(loIdx) && !q.winHigh)
    else $error("wrong low winner");
  set_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.seq == CALL && q.callCnt == 3'h1 && q.winHigh |=> inService[1])
    else $error("high level not marked active");
  release_hi_a: assert property (@(posedge clk) disable iff (sys_rst)
    retiDone && q.active[1] |=> !inService[1])
    else $error("high level not released");
  release_lo_a: assert property (@(posedge clk) disable iff (sys_rst)
    retiDone && q.active == 2'b01 |=> inService == 2'b00)
    else $error("low level not released");
  // Main scenarios
  calls_c: cover property (@(posedge clk) callReq);
  preempt_c: cover property (@(posedge clk) callReq && q.winHigh && q.active[0]);
  ret_c: cover property (@(posedge clk) retiDone ##[1:20] callReq);
  low_c: cover property (@(posedge clk) callReq && !q.winHigh);
endmodule : irq_ctrl

/* core/irq_ctrl_consts.svh */
// Operation
// - Sample and resolve pending flags every clock
// - Best response: one detect, four call clocks
// - After return, one more instruction before call
// - Worst response eighteen clocks via return and divide
// - Equal or higher service blocks until return plus one
// - Enable register A layout, resets zero
// - Priority register A, top bits read one
// - Enable register B layout for eight sources
// - Enable register C layout for eight sources
// - Priority register B mirrors enable B, resets zero
// - Priority register C mirrors enable C, resets zero
// - Priority one high; enable one passes
// - High preempts low; high never preempted
// - Higher level wins, then lowest source number
// - Finish current instruction, then call source vector
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
`define ADDR_ENABLE_A 8'hA8
`define ADDR_PRIORITY_A 8'hB8
`define ADDR_ENABLE_B 8'hE6
`define ADDR_ENABLE_C 8'hE7
`define ADDR_PRIORITY_B 8'hF6
`define ADDR_PRIORITY_C 8'hF7
`define RESET_ENABLE 8'h00
`define RESET_PRIORITY_A 8'hC0
`define PRIORITY_A_FIXED 8'hC0
`define GLOBAL_ON_BIT 7
`define NUM_SOURCES 22
`define CALL_CLOCKS 4
`define VECTOR_BASE 16'h0003
`define VECTOR_STEP 16'h0008
`endif

/* core/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;
  typedef enum logic [1:0] {IDLE, DETECT, CALL, HOLD} seq_t;
endpackage : irq_ctrl_pkg

/* core/prio_pick.sv */
`timescale 1ns/1ps
`include "irq_ctrl_consts.svh"
module prio_pick #(
  parameter int N = 22
) (
  input wire logic [N-1:0] req, // Candidate sources
  output logic found, // Any candidate
  output logic [4:0] index // Lowest numbered candidate
);
  // Lowest source number wins
  always_comb begin
    found = 1'b0;
    index = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        index = 5'(i);
      end
    end
  end
endmodule : prio_pick

/* verification/core_model.sv */
`timescale 1ns/1ps
module core_model (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic callReq, // Call request from controller
  input wire logic retiCmd, // Bench asks for a return
  output logic instrDone, // Instruction boundary pulse
  output logic retiDone, // Return finished pulse
  output logic callDone // Call finished pulse
);
  logic [2:0] callCnt;
  logic phase;
  // Two-clock instructions, four-clock call, return on command
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      callCnt <= 3'h0;
      phase <= 1'b0;
      instrDone <= 1'b0;
      retiDone <= 1'b0;
      callDone <= 1'b0;
    end else begin
      phase <= ~phase;
      instrDone <= phase && callCnt == 3'h0;
      retiDone <= retiCmd;
      callDone <= callCnt == 3'h1;
      if (callReq) begin
        callCnt <= 3'h4;
      end else if (callCnt != 3'h0) begin
        callCnt <= callCnt - 3'h1;
      end
    end
  end
endmodule : core_model

/* verification/two_level_interrupt_controller_tb_top.sv */
`timescale 1ns/1ps
`include "irq_ctrl_consts.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module two_level_interrupt_controller_tb_top;
  logic clk = 0, sys_rst = 1, regWr = 0, retiCmd = 0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [21:0] pendFlags = 22'h000000;
  logic instrDone, retiDone, callDone, callReq;
  logic [15:0] callVector;
  logic [1:0] inService;
  int err_count = 0, compares = 0, cycles = 0;
  irq_ctrl dut (.clk(clk), .sys_rst(sys_rst), .pendFlags(pendFlags), .regWr(regWr), .regAddr(regAddr),
    .regWdata(regWdata), .instrDone(instrDone), .retiDone(retiDone), .callDone(callDone),
    .regRdata(regRdata), .callReq(callReq), .callVector(callVector), .inService(inService));
  core_model core (.clk(clk), .sys_rst(sys_rst), .callReq(callReq), .retiCmd(retiCmd),
    .instrDone(instrDone), .retiDone(retiDone), .callDone(callDone));
  // Clock and hang guard
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run;
    end
  end
  task complete_run;
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWdata <= d; end
    @(posedge clk) regWr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) regAddr <= a;
    @(posedge clk);
    #1 `CHK("regRdata", e, regRdata)
  endtask : rd
  // Wait for a call, then check vector and active levels
  task call(input logic [15:0] v, input logic [1:0] s);
    int k;
    k = 0;
    while (callReq !== 1'b1 && k < 30) begin @(posedge clk); #1 k++; end
    `CHK("callWait", 1'b1, k < 4)
    `CHK("callVector", v, callVector)
    repeat (5) @(posedge clk);
    #1 `CHK("inService", s, inService)
  endtask : call
  task quiet(input int n);
    int c;
    c = 0;
    repeat (n) begin @(posedge clk); #1 if (callReq === 1'b1) c++; end
    `CHK("callCount", 0, c)
  endtask : quiet
  task ret(input logic [1:0] s);
    @(posedge clk) retiCmd <= 1'b1;
    @(posedge clk) retiCmd <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK("inService", s, inService)
  endtask : ret
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`ADDR_ENABLE_A, 8'h00);
    rd(`ADDR_PRIORITY_A, 8'hC0);
    rd(`ADDR_ENABLE_B, 8'h00);
    rd(`ADDR_ENABLE_C, 8'h00);
    rd(`ADDR_PRIORITY_B, 8'h00);
    rd(`ADDR_PRIORITY_C, 8'h00);
    rd(8'h10, 8'h00);
    wr(`ADDR_PRIORITY_A, 8'h00);
    rd(`ADDR_PRIORITY_A, 8'hC0);
    wr(`ADDR_ENABLE_C, 8'h80);
    rd(`ADDR_ENABLE_C, 8'h80);
    wr(`ADDR_PRIORITY_C, 8'h80);
    rd(`ADDR_PRIORITY_C, 8'h80);
    wr(`ADDR_PRIORITY_B, 8'h01);
    rd(`ADDR_PRIORITY_B, 8'h01);
    wr(`ADDR_ENABLE_A, 8'h7F);
    @(posedge clk) pendFlags <= 22'h000009;
    quiet(20);
    wr(`ADDR_PRIORITY_A, 8'h08);
    wr(`ADDR_ENABLE_A, 8'hFF);
    call(16'h001B, 2'b10);
    @(posedge clk) pendFlags <= 22'h000001;
    quiet(20);
    ret(2'b00);
    call(16'h0003, 2'b01);
    @(posedge clk) pendFlags <= 22'h200000;
    call(16'h00AB, 2'b11);
    @(posedge clk) pendFlags <= 22'h000000;
    ret(2'b01);
    ret(2'b00);
    complete_run;
  end
endmodule : two_level_interrupt_controller_tb_top
